// File: hw/spfwc_pkg.sv
// Shared constants and types for the serial paged flash write control block.
package spfwc_pkg;
    localparam int unsigned ADDR_W = 21;
    localparam int unsigned FIFO_W = 8;
    localparam int unsigned FIFO_D = 16;
    // Opcodes.
    localparam logic [7:0] OP_SET_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_PERMIT = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_STORE = 8'h01;
    localparam logic [7:0] OP_PAGE_REWRITE = 8'h0A;
    localparam logic [7:0] OP_PAGE_BURN = 8'h02;
    localparam logic [7:0] OP_PAGE_WIPE = 8'hDB;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'hD8;
    localparam logic [7:0] OP_SUBSECTOR_WIPE = 8'h20;
    localparam logic [7:0] OP_FULL_ARRAY_WIPE = 8'hC7;
    localparam logic [7:0] OP_LOCK_STORE = 8'hE5;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;
    // Header byte counts.
    localparam logic [2:0] HDR_CMD_ONLY = 3'h1;
    localparam logic [2:0] HDR_CMD_DATA = 3'h2;
    localparam logic [2:0] HDR_FULL = 3'h4;
    localparam logic [2:0] HDR_LAST_ADDR = 3'h3;
    // Status register layout and reset values.
    localparam int unsigned SR_CYCLE_BIT = 0;
    localparam int unsigned SR_PERMIT_BIT = 1;
    localparam logic [7:0] SR_RST = 8'h00;
    localparam logic [7:0] SR_STORE_MASK = 8'hFC;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] LAST_IDX = 8'hFF;
    // Address span masks for page, subsector, sector and full array.
    localparam logic [ADDR_W-1:0] SPAN_PAGE = 21'h0_00FF;
    localparam logic [ADDR_W-1:0] SPAN_SUBSECTOR = 21'h0_0FFF;
    localparam logic [ADDR_W-1:0] SPAN_SECTOR = 21'h0_FFFF;
    localparam logic [ADDR_W-1:0] SPAN_ALL = 21'h1F_FFFF;
    typedef enum logic [2:0] {
        JOB_NONE = 3'b000,
        JOB_REWRITE = 3'b001,
        JOB_BURN = 3'b010,
        JOB_WIPE = 3'b011,
        JOB_STATUS = 3'b100,
        JOB_LOCK = 3'b101
    } spfwc_job_e;
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_MERGE = 3'b001,
        SQ_WIPE = 3'b010,
        SQ_PROG = 3'b011,
        SQ_BURN = 3'b100,
        SQ_RWAIT = 3'b101,
        SQ_RCAP = 3'b110,
        SQ_DONE = 3'b111
    } spfwc_seq_e;
endpackage

// File: hw/spfwc_top.sv
// Serial paged flash write control: SPI slave, data FIFO, page buffer and write sequencer.
`timescale 1ns/1ps

module spfwc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem_r[rp_r];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wp_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // spfwc_fifo

// What this block does
// - Works with masters in clock mode zero-zero or one-one only.
// - Samples input on rising clock edges, shifts output from falling edges.
// - At most 256 data bytes per sequence, consecutive within one page.
// - Data bytes fill the page buffer from the low address byte onward.
// - The internal rewrite cycle starts when select returns high.
// - Unsupplied buffer bytes are filled from the addressed page first.
// - After merging, the page is erased, then programmed with the buffer.
// - Burning changes up to 256 bytes, only turning ones into zeros.
// - A cycle-active status flag shows rewrite, burn, wipe and status-store cycles.
// - Device is active whenever select is low, except while the reset pin is held low.
// - After select rises, device stays active until internal cycles finish.
// - Deep sleep is entered only by the deep-sleep command.
// - In deep sleep only wake is accepted; everything else is ignored.
// - Status register is readable and its control bits writable by commands.
// - Modifying commands need a clock pulse count that is a multiple of eight.
// - Write-permit latch clears on reset, pin reset and modifying command completion.
module spfwc_top
    import spfwc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    input wire logic i_flash_rst_n,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    output logic [ADDR_W-1:0] o_arr_addr,
    output logic o_arr_rd,
    output logic o_arr_wr,
    output logic [7:0] o_arr_wdata,
    input wire logic [7:0] i_arr_rdata,
    output logic o_cycle_active,
    output logic o_write_permit,
    output logic o_pwr_active,
    output logic o_pwr_deep,
    output logic o_overrun
);
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic cs_s1_r, cs_s2_r, cs_s3_r;
    logic mosi_s1_r, mosi_s2_r;
    logic hrst_s1_r, hrst_s2_r;
    logic sclk_rise, sclk_fall, sel, cs_rise, pin_rst;
    logic [2:0] bit_cnt_r;
    logic [6:0] rx_sr_r;
    logic [7:0] rx_byte;
    logic byte_done;
    logic [2:0] hdr_cnt_r;
    logic [7:0] cmd_r;
    logic [23:0] addr_r;
    logic [7:0] sr_data_r;
    logic got_data_r;
    logic [7:0] tx_sr_r;
    logic miso_r, oe_r;
    logic wel_r, deep_r;
    logic [7:0] sr_bits_r;
    logic [7:0] status;
    logic cycle_active_flag;
    spfwc_job_e job_r, job_cur_r;
    spfwc_seq_e seq_r;
    logic [ADDR_W-1:0] base_r, last_r, wa_r, wlast_r;
    logic [12:0] pg_r, pg_cur_r;
    logic [7:0] idx_r;
    logic [7:0] ld_ptr_r;
    logic [7:0] buf_r [256];
    logic [255:0] loaded_r;
    logic is_page_cmd, hdr_ok, wr_ok, start, seq_done;
    logic push_v, fifo_in_ready, fifo_out_valid, pop;
    logic [7:0] fifo_data;
    logic arr_rd_r, arr_wr_r;
    logic [ADDR_W-1:0] arr_addr_r;
    logic [7:0] arr_wdata_r;
    logic pwr_active_r, pwr_deep_r, overrun_r;

    // Pins come from another clock domain; two flops each before use.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
            {cs_s1_r, cs_s2_r, cs_s3_r} <= 3'h7;
            {mosi_s1_r, mosi_s2_r} <= 2'h0;
            // Park at the pin's idle (released) level so no false pin reset follows a system reset.
            {hrst_s1_r, hrst_s2_r} <= 2'h3;
        end else begin
            {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {i_spi_sclk, sclk_s1_r, sclk_s2_r};
            {cs_s1_r, cs_s2_r, cs_s3_r} <= {i_spi_cs_n, cs_s1_r, cs_s2_r};
            {mosi_s1_r, mosi_s2_r} <= {i_spi_mosi, mosi_s1_r};
            {hrst_s1_r, hrst_s2_r} <= {i_flash_rst_n, hrst_s1_r};
        end
    end

    // Only edges matter, so the idle clock level chosen by the master is irrelevant.
    assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
    assign sclk_fall = ~sclk_s2_r & sclk_s3_r;
    assign sel = ~cs_s2_r & ~pin_rst;
    assign cs_rise = cs_s2_r & ~cs_s3_r;
    assign pin_rst = ~hrst_s2_r;
    assign rx_byte = {rx_sr_r, mosi_s2_r};
    assign byte_done = sel & sclk_rise & (bit_cnt_r == 3'h7);
    assign status = {sr_bits_r[7:2], wel_r, cycle_active_flag};
    assign cycle_active_flag = (seq_r != SQ_IDLE) | (job_r != JOB_NONE);
    assign is_page_cmd = (cmd_r == OP_PAGE_REWRITE) | (cmd_r == OP_PAGE_BURN);
    assign wr_ok = wel_r & ~cycle_active_flag & ~deep_r;
    assign hdr_ok = (bit_cnt_r == 3'h0) & ~pin_rst;
    assign push_v = byte_done & (hdr_cnt_r == HDR_FULL) & is_page_cmd & wr_ok;
    assign pop = fifo_out_valid & (seq_r == SQ_IDLE);
    assign start = (seq_r == SQ_IDLE) & (job_r != JOB_NONE) & ~fifo_out_valid & ~pin_rst;
    assign seq_done = (seq_r == SQ_DONE);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bit_cnt_r <= 3'h0;
            rx_sr_r <= 7'h00;
        end else if (!sel) begin
            bit_cnt_r <= 3'h0;
            rx_sr_r <= 7'h00;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sr_r <= rx_byte[6:0];
        end
    end

    // Header decode: command, three address bytes, status data byte.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hdr_cnt_r <= 3'h0;
            cmd_r <= 8'h00;
            addr_r <= 24'h00_0000;
            sr_data_r <= 8'h00;
            got_data_r <= 1'b0;
        end else if (!sel && !cs_rise) begin
            hdr_cnt_r <= 3'h0;
            got_data_r <= 1'b0;
        end else if (byte_done) begin
            if (hdr_cnt_r == 3'h0) begin
                cmd_r <= rx_byte;
            end else if (hdr_cnt_r != HDR_FULL) begin
                addr_r <= {addr_r[15:0], rx_byte};
            end
            if (hdr_cnt_r == HDR_CMD_ONLY) begin
                sr_data_r <= rx_byte;
            end
            if (hdr_cnt_r != HDR_FULL) begin
                hdr_cnt_r <= hdr_cnt_r + 3'h1;
            end else begin
                got_data_r <= 1'b1;
            end
        end
    end

    // Status is reloaded at every byte so the master can poll continuously.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_sr_r <= 8'h00;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            oe_r <= sel & ~deep_r;
            if (!sel) begin
                tx_sr_r <= 8'h00;
                miso_r <= 1'b0;
            end else if (byte_done) begin
                if (!deep_r && ((hdr_cnt_r == 3'h0 && rx_byte == OP_STATUS_READ) ||
                    (hdr_cnt_r != 3'h0 && cmd_r == OP_STATUS_READ))) begin
                    tx_sr_r <= status;
                end else begin
                    tx_sr_r <= 8'h00;
                end
            end else if (sclk_fall) begin
                miso_r <= tx_sr_r[7];
                tx_sr_r <= {tx_sr_r[6:0], 1'b0};
            end
        end
    end

    // Command decision when select returns high.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            job_r <= JOB_NONE;
            base_r <= '0;
            last_r <= '0;
            pg_r <= 13'h0000;
        end else if (pin_rst || start) begin
            job_r <= JOB_NONE;
        end else if (cs_rise && hdr_ok && wr_ok) begin
            pg_r <= addr_r[20:8];
            base_r <= addr_r[ADDR_W-1:0] & ~SPAN_PAGE;
            last_r <= addr_r[ADDR_W-1:0] | SPAN_PAGE;
            if (is_page_cmd && hdr_cnt_r == HDR_FULL && got_data_r) begin
                job_r <= (cmd_r == OP_PAGE_REWRITE) ? JOB_REWRITE : JOB_BURN;
            end else if (hdr_cnt_r == HDR_FULL && cmd_r == OP_PAGE_WIPE) begin
                job_r <= JOB_WIPE;
            end else if (hdr_cnt_r == HDR_FULL && cmd_r == OP_SUBSECTOR_WIPE) begin
                job_r <= JOB_WIPE;
                base_r <= addr_r[ADDR_W-1:0] & ~SPAN_SUBSECTOR;
                last_r <= addr_r[ADDR_W-1:0] | SPAN_SUBSECTOR;
            end else if (hdr_cnt_r == HDR_FULL && cmd_r == OP_SECTOR_WIPE) begin
                job_r <= JOB_WIPE;
                base_r <= addr_r[ADDR_W-1:0] & ~SPAN_SECTOR;
                last_r <= addr_r[ADDR_W-1:0] | SPAN_SECTOR;
            end else if (hdr_cnt_r == HDR_CMD_ONLY && cmd_r == OP_FULL_ARRAY_WIPE) begin
                job_r <= JOB_WIPE;
                base_r <= '0;
                last_r <= SPAN_ALL;
            end else if (hdr_cnt_r == HDR_CMD_DATA && cmd_r == OP_STATUS_STORE) begin
                job_r <= JOB_STATUS;
            end else if (hdr_cnt_r == HDR_FULL && cmd_r == OP_LOCK_STORE) begin
                job_r <= JOB_LOCK;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wel_r <= 1'b0;
        end else if (pin_rst || seq_done) begin
            wel_r <= 1'b0;
        end else if (cs_rise && hdr_ok && !deep_r && hdr_cnt_r == HDR_CMD_ONLY && !cycle_active_flag) begin
            if (cmd_r == OP_SET_WRITE_PERMIT) begin
                wel_r <= 1'b1;
            end else if (cmd_r == OP_CLEAR_WRITE_PERMIT) begin
                wel_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            deep_r <= 1'b0;
        end else if (pin_rst) begin
            deep_r <= 1'b0;
        end else if (cs_rise && hdr_ok && hdr_cnt_r == HDR_CMD_ONLY) begin
            if (deep_r && cmd_r == OP_WAKE) begin
                deep_r <= 1'b0;
            end else if (!deep_r && !cycle_active_flag && cmd_r == OP_DEEP_SLEEP) begin
                deep_r <= 1'b1;
            end
        end
    end

    // The SPI side cannot be stalled; a byte refused by a full FIFO is flagged.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            overrun_r <= 1'b0;
        end else if (push_v && !fifo_in_ready) begin
            overrun_r <= 1'b1;
        end
    end

    spfwc_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(push_v),
        .o_in_ready(fifo_in_ready),
        .i_in_data(rx_byte),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(seq_r == SQ_IDLE),
        .o_out_data(fifo_data)
    );

    // Byte position wraps inside the page, so long sequences stay in one page.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ld_ptr_r <= 8'h00;
            loaded_r <= '0;
        end else if (byte_done && hdr_cnt_r == HDR_LAST_ADDR && is_page_cmd && wr_ok) begin
            ld_ptr_r <= rx_byte;
            loaded_r <= '0;
        end else if (pop) begin
            ld_ptr_r <= ld_ptr_r + 8'h01;
            loaded_r[ld_ptr_r] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (pop) begin
            buf_r[ld_ptr_r] <= fifo_data;
        end else if (seq_r == SQ_RCAP && job_cur_r == JOB_REWRITE) begin
            buf_r[idx_r] <= i_arr_rdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sr_bits_r <= SR_RST;
        end else if (start && job_r == JOB_STATUS) begin
            sr_bits_r <= sr_data_r & SR_STORE_MASK;
        end
    end

    // Internal cycle sequencer; array reads return data two cycles after the state issues them.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            seq_r <= SQ_IDLE;
            job_cur_r <= JOB_NONE;
            idx_r <= 8'h00;
            wa_r <= '0;
            wlast_r <= '0;
            pg_cur_r <= 13'h0000;
            arr_rd_r <= 1'b0;
            arr_wr_r <= 1'b0;
            arr_addr_r <= '0;
            arr_wdata_r <= 8'h00;
        end else if (pin_rst) begin
            seq_r <= SQ_IDLE;
            arr_rd_r <= 1'b0;
            arr_wr_r <= 1'b0;
        end else begin
            arr_rd_r <= 1'b0;
            arr_wr_r <= 1'b0;
            unique case (seq_r)
                SQ_IDLE: begin
                    if (start) begin
                        job_cur_r <= job_r;
                        idx_r <= 8'h00;
                        wa_r <= base_r;
                        wlast_r <= last_r;
                        pg_cur_r <= pg_r;
                        unique case (job_r)
                            JOB_REWRITE: seq_r <= SQ_MERGE;
                            JOB_BURN: seq_r <= SQ_BURN;
                            JOB_WIPE: seq_r <= SQ_WIPE;
                            default: seq_r <= SQ_DONE;
                        endcase
                    end
                end
                SQ_MERGE: begin
                    if (!loaded_r[idx_r]) begin
                        arr_rd_r <= 1'b1;
                        arr_addr_r <= {pg_cur_r, idx_r};
                        seq_r <= SQ_RWAIT;
                    end else if (idx_r == LAST_IDX) begin
                        seq_r <= SQ_WIPE;
                    end else begin
                        idx_r <= idx_r + 8'h01;
                    end
                end
                SQ_BURN: begin
                    if (loaded_r[idx_r]) begin
                        arr_rd_r <= 1'b1;
                        arr_addr_r <= {pg_cur_r, idx_r};
                        seq_r <= SQ_RWAIT;
                    end else if (idx_r == LAST_IDX) begin
                        seq_r <= SQ_DONE;
                    end else begin
                        idx_r <= idx_r + 8'h01;
                    end
                end
                SQ_RWAIT: begin
                    seq_r <= SQ_RCAP;
                end
                SQ_RCAP: begin
                    if (job_cur_r == JOB_BURN) begin
                        arr_wr_r <= 1'b1;
                        arr_addr_r <= {pg_cur_r, idx_r};
                        arr_wdata_r <= i_arr_rdata & buf_r[idx_r];
                    end
                    if (idx_r == LAST_IDX) begin
                        seq_r <= (job_cur_r == JOB_BURN) ? SQ_DONE : SQ_WIPE;
                    end else begin
                        idx_r <= idx_r + 8'h01;
                        seq_r <= (job_cur_r == JOB_BURN) ? SQ_BURN : SQ_MERGE;
                    end
                end
                SQ_WIPE: begin
                    arr_wr_r <= 1'b1;
                    arr_addr_r <= wa_r;
                    arr_wdata_r <= ERASED_BYTE;
                    if (wa_r == wlast_r) begin
                        idx_r <= 8'h00;
                        seq_r <= (job_cur_r == JOB_REWRITE) ? SQ_PROG : SQ_DONE;
                    end else begin
                        wa_r <= wa_r + 1'b1;
                    end
                end
                SQ_PROG: begin
                    arr_wr_r <= 1'b1;
                    arr_addr_r <= {pg_cur_r, idx_r};
                    arr_wdata_r <= buf_r[idx_r];
                    if (idx_r == LAST_IDX) begin
                        seq_r <= SQ_DONE;
                    end else begin
                        idx_r <= idx_r + 8'h01;
                    end
                end
                SQ_DONE: begin
                    seq_r <= SQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pwr_active_r <= 1'b0;
            pwr_deep_r <= 1'b0;
        end else begin
            pwr_active_r <= sel | cycle_active_flag;
            pwr_deep_r <= deep_r;
        end
    end

    assign o_spi_miso = miso_r;
    assign o_spi_miso_oe = oe_r;
    assign o_arr_addr = arr_addr_r;
    assign o_arr_rd = arr_rd_r;
    assign o_arr_wr = arr_wr_r;
    assign o_arr_wdata = arr_wdata_r;
    assign o_cycle_active = cycle_active_flag;
    assign o_write_permit = wel_r;
    assign o_pwr_active = pwr_active_r;
    assign o_pwr_deep = pwr_deep_r;
    assign o_overrun = overrun_r;
endmodule // spfwc_top

// File: testbench/spfwc_array_model.sv
// Behavioural flash array standing behind the array port of the block.
`timescale 1ns/1ps
module spfwc_array_model
    import spfwc_pkg::*;
(
    input wire logic i_clk,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata = 8'h00
);
    logic [7:0] mem [int];
    // Read data stands for one cycle only, then it is scrambled so a late capture is caught.
    always @(posedge i_clk) begin
        if (i_wr) begin
            mem[int'(i_addr)] = i_wdata;
        end
        if (i_rd) begin
            o_rdata <= mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : ERASED_BYTE;
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule // spfwc_array_model

// File: testbench/spfwc_assertions.sv
// Concurrent checks on the ports of the write control block.
`timescale 1ns/1ps
module spfwc_checker (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_flash_rst_n,
    input wire logic o_spi_miso_oe,
    input wire logic o_arr_rd,
    input wire logic o_arr_wr,
    input wire logic o_cycle_active,
    input wire logic o_write_permit,
    input wire logic o_pwr_active,
    input wire logic o_pwr_deep
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_sel; !i_spi_cs_n [*4] |-> o_pwr_active; endproperty
    a_sel: assert property (p_sel) else $error("not active while selected");
    property p_busy; o_cycle_active && $past(o_cycle_active) |-> o_pwr_active; endproperty
    a_busy: assert property (p_busy) else $error("not active during cycle");
    property p_stby; (i_spi_cs_n && !o_cycle_active) [*4] |-> !o_pwr_active; endproperty
    a_stby: assert property (p_stby) else $error("no standby when idle");
    property p_arr; o_arr_rd || o_arr_wr |-> o_cycle_active; endproperty
    a_arr: assert property (p_arr) else $error("array access outside a cycle");
    property p_start; $rose(o_cycle_active) |-> i_spi_cs_n && $past(o_write_permit); endproperty
    a_start: assert property (p_start) else $error("cycle started badly");
    property p_clr; $fell(o_cycle_active) |-> ##[0:2] !o_write_permit; endproperty
    a_clr: assert property (p_clr) else $error("permit kept after cycle");
    property p_deep; o_pwr_deep |-> !$rose(o_write_permit) && !o_cycle_active; endproperty
    a_deep: assert property (p_deep) else $error("command taken in deep sleep");
    property p_dent; $rose(o_pwr_deep) |-> i_spi_cs_n; endproperty
    a_dent: assert property (p_dent) else $error("deep sleep entered while selected");
    property p_oe; i_spi_cs_n [*4] |-> !o_spi_miso_oe; endproperty
    a_oe: assert property (p_oe) else $error("output driven while deselected");
    property p_prst; !i_flash_rst_n [*5] |-> !o_write_permit && !o_cycle_active && !o_pwr_deep; endproperty
    a_prst: assert property (p_prst) else $error("pin reset ignored");
    c_cyc: cover property ($rose(o_cycle_active));
    c_deep: cover property ($rose(o_pwr_deep));
    c_wp: cover property ($rose(o_write_permit));
endmodule // spfwc_checker
bind spfwc_top spfwc_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_spi_cs_n(i_spi_cs_n),
    .i_flash_rst_n(i_flash_rst_n), .o_spi_miso_oe(o_spi_miso_oe), .o_arr_rd(o_arr_rd), .o_arr_wr(o_arr_wr),
    .o_cycle_active(o_cycle_active), .o_write_permit(o_write_permit), .o_pwr_active(o_pwr_active),
    .o_pwr_deep(o_pwr_deep));

// File: testbench/spfwc_top_tb.sv
// Self-checking bench: SPI master tasks, page model and array partner.
`timescale 1ns/1ps
module spfwc_top_tb;
    import spfwc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sclk = 1'b0, cs_n = 1'b1, mosi = 1'b0, frst_n = 1'b1, cpol = 1'b0;
    logic miso, oe, arr_rd, arr_wr, cyc, wp, act, deep, ovr;
    logic [ADDR_W-1:0] arr_addr;
    logic [7:0] arr_wd, arr_rdat, r, d;
    logic [7:0] tx[$], rx[$], pg[256];
    int bad_count = 0, n_compared = 0, o;
    always #5 clk = ~clk;
    spfwc_top dut (.i_clk(clk), .i_sys_rst(rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
        .i_flash_rst_n(frst_n), .o_spi_miso(miso), .o_spi_miso_oe(oe), .o_arr_addr(arr_addr), .o_arr_rd(arr_rd),
        .o_arr_wr(arr_wr), .o_arr_wdata(arr_wd), .i_arr_rdata(arr_rdat), .o_cycle_active(cyc),
        .o_write_permit(wp), .o_pwr_active(act), .o_pwr_deep(deep), .o_overrun(ovr));
    spfwc_array_model u_arr (.i_clk(clk), .i_addr(arr_addr), .i_rd(arr_rd), .i_wr(arr_wr), .i_wdata(arr_wd),
        .o_rdata(arr_rdat));
    task automatic test_done();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Sclk period is 16 system clocks; miso is taken just before the rising edge.
    task automatic xb(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            mosi = b[i];
            repeat (8) @(negedge clk);
            r[i] = miso;
            sclk = 1'b1;
            repeat (8) @(negedge clk);
        end
        rx.push_back(r);
    endtask
    task automatic frame();
        // The idle level must settle while deselected, or a mode change looks like a clock edge.
        sclk = cpol;
        repeat (8) @(negedge clk);
        cs_n = 1'b0;
        rx = {};
        repeat (8) @(negedge clk);
        foreach (tx[k]) xb(tx[k]);
        sclk = cpol;
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        repeat (16) @(negedge clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        tx = {op};
        frame();
    endtask
    task automatic wait_done();
        for (int k = 0; k < 5000 && cyc !== 1'b0; k++) @(negedge clk);
        chk8({7'h0, cyc}, 8'h00);
        chk8({7'h0, wp}, 8'h00);
        foreach (pg[i]) chk8(u_arr.mem[32'h0000_0500 + i], pg[i]);
        $display("test done at %0t", $time);
    endtask
    initial begin
        void'($urandom(66975));
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk8({4'h0, cyc, wp, deep, ovr}, 8'h00);
        foreach (pg[i]) begin
            pg[i] = 8'($urandom);
            u_arr.mem[32'h0000_0500 + i] = pg[i];
        end
        tx = {OP_PAGE_BURN, 8'h00, 8'h05, 8'h10, 8'h00};
        frame();
        wait_done();
        cpol = 1'b1;
        cmd(OP_SET_WRITE_PERMIT);
        chk8({7'h0, wp}, 8'h01);
        tx = {OP_STATUS_READ, 8'h00};
        frame();
        chk8(rx[1], 8'h02);
        cmd(OP_CLEAR_WRITE_PERMIT);
        chk8({7'h0, wp}, 8'h00);
        $display("test done at %0t", $time);
        cpol = 1'b0;
        cmd(OP_SET_WRITE_PERMIT);
        tx = {OP_PAGE_BURN, 8'h00, 8'h05, LAST_IDX - 8'h01};
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            tx.push_back(d);
            pg[254 + i] &= d;
        end
        frame();
        wait_done();
        o = $urandom_range(253, 0);
        cmd(OP_SET_WRITE_PERMIT);
        tx = {OP_PAGE_REWRITE, 8'h00, 8'h05, 8'(o)};
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            tx.push_back(d);
            pg[o + i] = d;
        end
        frame();
        tx = {OP_STATUS_READ, 8'h00};
        frame();
        chk8({7'h0, rx[1][SR_CYCLE_BIT]}, 8'h01);
        wait_done();
        cmd(OP_DEEP_SLEEP);
        chk8({7'h0, deep}, 8'h01);
        cmd(OP_SET_WRITE_PERMIT);
        chk8({7'h0, wp}, 8'h00);
        cmd(OP_WAKE);
        chk8({7'h0, deep}, 8'h00);
        $display("test done at %0t", $time);
        cmd(OP_SET_WRITE_PERMIT);
        frst_n = 1'b0;
        repeat (10) @(negedge clk);
        frst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk8({6'h00, wp, ovr}, 8'h00);
        $display("test done at %0t", $time);
        test_done();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule // spfwc_top_tb
